// ### common/vlpl_pkg.sv
// constants and types shared by the link low-power, loopback and receive-filter block
package vlpl_pkg;

   localparam int CLK_MHZ = 50;

   // register byte offsets
   localparam logic [11:0] OFF_CTRL_ONE  = 12'h000;
   localparam logic [11:0] OFF_CTRL_TWO  = 12'h004;
   localparam logic [11:0] OFF_STATE_VEC = 12'h008;
   localparam logic [11:0] OFF_STATUS    = 12'h00C;

   // link_control_one fields
   localparam int BIT_WAIT_STOP = 0;
   // link_control_two fields
   localparam int BIT_DIGITAL_LOOP_ENABLE     = 0;
   localparam int BIT_ANALOG_LOOP_ENABLE     = 1;
   localparam int BIT_FAST      = 2;
   // status fields
   localparam int ST_MODE_LO    = 0;
   localparam int ST_MODE_HI    = 1;
   localparam int ST_RXF        = 2;
   localparam int ST_IDLE_WAIT  = 3;
   localparam int ST_IN_FRAME   = 4;

   // state vector codes, wakeup highest
   localparam logic [7:0] SV_NONE     = 8'h00;
   localparam logic [7:0] SV_EOF      = 8'h04;
   localparam logic [7:0] SV_INVALID  = 8'h08;
   localparam logic [7:0] SV_TOO_LONG = 8'h0C;
   localparam logic [7:0] SV_WAKEUP   = 8'h20;

   // filter end points
   localparam logic [3:0] FILT_MAX = 4'hF;
   localparam logic [3:0] FILT_MIN = 4'h0;

   // symbol times in microseconds
   localparam int EOD_US     = 200;
   localparam int EOF_US     = 280;
   localparam int IDLE_US    = 300;
   localparam int MIN_SYM_US = 60;

   localparam int EOD_CYC_DEF  = EOD_US * CLK_MHZ;
   localparam int EOF_CYC_DEF  = EOF_US * CLK_MHZ;
   localparam int IDLE_CYC_DEF = IDLE_US * CLK_MHZ;
   localparam logic [15:0] MIN_SYM_CYC = 16'(MIN_SYM_US * CLK_MHZ);

   // message length limit, counted in filtered edges
   localparam int MAX_MSG_BYTES = 12;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [7:0] MAX_EDGES = 8'(MAX_MSG_BYTES * BITS_PER_BYTE + 1);

   typedef enum logic [1:0] {
      VLPL_RUN,
      VLPL_WAIT,
      VLPL_STOP,
      VLPL_WAKE
   } vlpl_pmode_t;

endpackage

// ### verilog/vlpl_link.sv
// link low-power modes, loopback paths and receive noise filter with apb registers
//
// Contract
// - wait instruction with select clear enters link wait; clocks keep running.
// - wait instruction with select set enters link stop; link clocks halt.
// - stop instruction with select set enters link stop; everything halts.
// - link wait drives no bus; first rising edge raises interrupt, message kept.
// - leaving stop raises non-maskable wakeup, reported as top state vector code.
// - low-power modes never reset any register.
// - stop wakeup on first rising edge; clocks stay halted until cpu acknowledges.
// - waking message after full stop need not be received correctly.
// - with a loopback bit set, sleeping controller ignores bus traffic.
// - analog loop needs transceiver loop first; digital loop sets only its bit.
// - digital loop joins transmit to receive internally, bus not driven.
// - analog loop changes nothing; after exit wait for idle bus.
// - filter samples input each clock, counts on the following step.
// - counter up on high, down on low, saturating at 15 and 0.
// - output latch set at 15, cleared at 0, held otherwise.
// - clean transition reaches filter output after 15 to 16 periods; the code takes 17 from the filter input, 19 from the pin.
// - pulses below filter delay vanish; short symbols flagged invalid.
// - message holds at most 12 bytes beyond framing symbols, msb first.
// - wakeup behaviour identical in normal and fast receive mode.
`timescale 1ns/100ps
module vlpl_link
   import vlpl_pkg::*;
#(
   parameter logic [15:0] EOD_CYC  = 16'(EOD_CYC_DEF),
   parameter logic [15:0] EOF_CYC  = 16'(EOF_CYC_DEF),
   parameter logic [15:0] IDLE_CYC = 16'(IDLE_CYC_DEF)
)
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        cpu_wait_i,
   input  wire logic        cpu_stop_i,
   input  wire logic        tx_bit_i,
   input  wire logic        link_rx_in_i,
   output logic             link_tx_out_o,
   output logic             rx_filtered_o,
   output logic             wake_irq_o,
   output logic             wake_nmi_o,
   output logic             link_clk_halted_o
);

   // sticky flag update; a set in the clearing cycle wins
   function automatic logic upd_flag(input logic set, input logic clr, input logic q);
      upd_flag = set | (q & ~clr);
   endfunction

   // registers
   logic        wait_stop_select_ff;
   logic        digital_loop_enable_ff;
   logic        analog_loop_enable_ff;
   logic        fast_receive_mode_ff;
   vlpl_pmode_t pmode_ff;
   vlpl_pmode_t nxt_pmode;
   logic        rx_meta_ff;
   logic        rx_sync_ff;
   logic        rx_prev_ff;
   logic        samp_ff;
   logic [3:0]  cnt_ff;
   logic [3:0]  nxt_cnt;
   logic        rxf_ff;
   logic        rxf_prev_ff;
   logic [15:0] run_cnt_ff;
   logic [7:0]  edge_cnt_ff;
   logic        in_frame_ff;
   logic        idle_wait_ff;
   logic        eof_flag_ff;
   logic        inv_flag_ff;
   logic        long_flag_ff;
   logic        wake_flag_ff;
   logic        irq_ff;
   logic        tx_ff;
   logic        halted_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [7:0]  sv_code_ff;

   // bus decode
   wire setup     = psel_i & ~penable_i;
   wire acc       = psel_i & penable_i & pready_ff;
   wire wr_acc    = acc & pwrite_i;
   wire rd_acc    = acc & ~pwrite_i;
   wire hit_one   = (paddr_i == OFF_CTRL_ONE);
   wire hit_two   = (paddr_i == OFF_CTRL_TWO);
   wire hit_sv    = (paddr_i == OFF_STATE_VEC);
   wire hit_st    = (paddr_i == OFF_STATUS);
   wire hit_any   = hit_one | hit_two | hit_sv | hit_st;
   wire wr_one    = wr_acc & hit_one;
   wire wr_two    = wr_acc & hit_two;
   wire sv_read   = rd_acc & hit_sv;

   // priority encode of pending events, wakeup first
   wire [7:0] sv_code = wake_flag_ff ? SV_WAKEUP :
                        long_flag_ff ? SV_TOO_LONG :
                        inv_flag_ff  ? SV_INVALID :
                        eof_flag_ff  ? SV_EOF : SV_NONE;

   // clears act on the code captured at setup, not on a newer event
   wire clr_wake  = sv_read & (sv_code_ff == SV_WAKEUP);
   wire clr_long  = sv_read & (sv_code_ff == SV_TOO_LONG);
   wire clr_inv   = sv_read & (sv_code_ff == SV_INVALID);
   wire clr_eof   = sv_read & (sv_code_ff == SV_EOF);

   wire [31:0] rd_one = {31'h0000_0000, wait_stop_select_ff};
   wire [31:0] rd_two = {29'h0000_0000, fast_receive_mode_ff,
                         analog_loop_enable_ff, digital_loop_enable_ff};
   wire [31:0] rd_st  = {27'h0000_000, in_frame_ff, idle_wait_ff, rxf_ff,
                         pmode_ff[ST_MODE_HI], pmode_ff[ST_MODE_LO]};
   wire [31:0] rd_mux = hit_one ? rd_one :
                        hit_two ? rd_two :
                        hit_sv  ? {24'h00_0000, sv_code} :
                        hit_st  ? rd_st : 32'h0000_0000;

   // analog loop exit: bit falls on a write
   wire analog_loop_enable_exit = wr_two & analog_loop_enable_ff & ~pwdata_i[BIT_ANALOG_LOOP_ENABLE];

   // controller clocks run only in run and wait
   wire clk_on = (pmode_ff == VLPL_RUN) | (pmode_ff == VLPL_WAIT);

   // transmit path; never in low power or before idle after analog loop
   wire tx_int = tx_bit_i & (pmode_ff == VLPL_RUN) & ~idle_wait_ff;
   wire tx_pin = digital_loop_enable_ff ? 1'b0 : tx_int;
   wire rx_src = digital_loop_enable_ff ? tx_int : rx_sync_ff;

   // filter arithmetic
   wire cnt_up = samp_ff & (cnt_ff != FILT_MAX);
   wire cnt_dn = ~samp_ff & (cnt_ff != FILT_MIN);

   // filtered-level timing
   wire filt_edge  = rxf_ff ^ rxf_prev_ff;
   wire run_at_max = (run_cnt_ff == IDLE_CYC);
   wire short_sym  = filt_edge & in_frame_ff & (run_cnt_ff < MIN_SYM_CYC);
   wire eof_hit    = in_frame_ff & ~rxf_ff & (run_cnt_ff >= EOF_CYC);
   wire eod_hit    = ~rxf_ff & (run_cnt_ff == EOD_CYC);
   wire too_long   = filt_edge & in_frame_ff & (edge_cnt_ff == MAX_EDGES);
   wire bus_idle   = ~rxf_ff & run_at_max;

   // raw passive-to-active edge; filter may be halted
   wire act_edge = rx_sync_ff & ~rx_prev_ff;
   // loopback bits keep a sleeping node deaf to the bus
   wire wake_ok  = act_edge & ~digital_loop_enable_ff & ~analog_loop_enable_ff;

   // power mode sequencing; fast receive mode plays no part
   always_comb
   begin
      nxt_pmode = pmode_ff;
      case (pmode_ff)
         VLPL_RUN:
         begin
            if (cpu_stop_i && wait_stop_select_ff)
               nxt_pmode = VLPL_STOP;
            else if (cpu_wait_i && wait_stop_select_ff)
               nxt_pmode = VLPL_STOP;
            else if (cpu_wait_i)
               nxt_pmode = VLPL_WAIT;
         end
         VLPL_WAIT:
         begin
            if (wake_ok)
               nxt_pmode = VLPL_RUN;
         end
         VLPL_STOP:
         begin
            // the waking message is lost while clocks settle
            if (wake_ok)
               nxt_pmode = VLPL_WAKE;
         end
         VLPL_WAKE:
         begin
            if (clr_wake)
               nxt_pmode = VLPL_RUN;
         end
         default:
         begin
            nxt_pmode = VLPL_RUN;
         end
      endcase
   end

   always_comb
   begin
      nxt_cnt = cnt_ff;
      if (clk_on && cnt_up)
         nxt_cnt = cnt_ff + 4'h1;
      else if (clk_on && cnt_dn)
         nxt_cnt = cnt_ff - 4'h1;
   end

   // apb slave: no wait states, data captured at setup
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         sv_code_ff <= SV_NONE;
      end
      else
      begin
         pready_ff  <= setup;
         pslverr_ff <= setup & ~hit_any;
         if (setup)
         begin
            prdata_ff  <= pwrite_i ? 32'h0000_0000 : rd_mux;
            sv_code_ff <= sv_code;
         end
      end
   end

   // control registers; low-power modes leave them alone
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wait_stop_select_ff    <= 1'b0;
         digital_loop_enable_ff <= 1'b0;
         analog_loop_enable_ff  <= 1'b0;
         fast_receive_mode_ff   <= 1'b0;
      end
      else
      begin
         if (wr_one)
            wait_stop_select_ff <= pwdata_i[BIT_WAIT_STOP];
         if (wr_two)
         begin
            digital_loop_enable_ff <= pwdata_i[BIT_DIGITAL_LOOP_ENABLE];
            analog_loop_enable_ff  <= pwdata_i[BIT_ANALOG_LOOP_ENABLE];
            fast_receive_mode_ff   <= pwdata_i[BIT_FAST];
         end
      end
   end

   // pin synchroniser and raw edge history
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rx_meta_ff <= 1'b0;
         rx_sync_ff <= 1'b0;
         rx_prev_ff <= 1'b0;
      end
      else
      begin
         rx_meta_ff <= link_rx_in_i;
         rx_sync_ff <= rx_meta_ff;
         rx_prev_ff <= rx_sync_ff;
      end
   end

   // filter: sample this edge, count from it on the next
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         samp_ff     <= 1'b0;
         cnt_ff      <= FILT_MIN;
         rxf_ff      <= 1'b0;
         rxf_prev_ff <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         if (clk_on)
         begin
            samp_ff     <= rx_src;
            rxf_prev_ff <= rxf_ff;
            // 15 agreeing samples needed, so short pulses die here
            if (cnt_ff == FILT_MAX)
               rxf_ff <= 1'b1;
            else if (cnt_ff == FILT_MIN)
               rxf_ff <= 1'b0;
         end
      end
   end

   // symbol length, frame and edge tracking on the filtered level
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         run_cnt_ff  <= 16'h0000;
         edge_cnt_ff <= 8'h00;
         in_frame_ff <= 1'b0;
      end
      else if (clk_on)
      begin
         if (filt_edge)
            run_cnt_ff <= 16'h0000;
         else if (!run_at_max)
            run_cnt_ff <= run_cnt_ff + 16'h0001;
         if (filt_edge && rxf_ff)
            in_frame_ff <= 1'b1;
         else if (eof_hit)
            in_frame_ff <= 1'b0;
         // counting restarts at end of data so a response is judged alone
         if (eod_hit || !in_frame_ff)
            edge_cnt_ff <= 8'h00;
         else if (filt_edge && edge_cnt_ff != MAX_EDGES)
            edge_cnt_ff <= edge_cnt_ff + 8'h01;
      end
   end

   // sticky event flags read through the state vector
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         eof_flag_ff  <= 1'b0;
         inv_flag_ff  <= 1'b0;
         long_flag_ff <= 1'b0;
         wake_flag_ff <= 1'b0;
      end
      else
      begin
         eof_flag_ff  <= upd_flag(clk_on & eof_hit, clr_eof, eof_flag_ff);
         inv_flag_ff  <= upd_flag(clk_on & short_sym, clr_inv, inv_flag_ff);
         long_flag_ff <= upd_flag(clk_on & too_long, clr_long, long_flag_ff);
         wake_flag_ff <= upd_flag((pmode_ff == VLPL_STOP) & wake_ok,
                                  clr_wake, wake_flag_ff);
      end
   end

   // power mode, idle wait and interrupt lines
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         pmode_ff     <= VLPL_RUN;
         idle_wait_ff <= 1'b0;
         irq_ff       <= 1'b0;
         tx_ff        <= 1'b0;
         halted_ff    <= 1'b0;
      end
      else
      begin
         pmode_ff     <= nxt_pmode;
         // exit wins over a coincident idle, so the wait is never skipped
         idle_wait_ff <= upd_flag(analog_loop_enable_exit, clk_on & bus_idle, idle_wait_ff);
         // wait wake request, dropped by any state vector read
         irq_ff       <= upd_flag((pmode_ff == VLPL_WAIT) & wake_ok, sv_read, irq_ff);
         tx_ff        <= tx_pin;
         halted_ff    <= (nxt_pmode == VLPL_STOP) | (nxt_pmode == VLPL_WAKE);
      end
   end

   assign prdata_o          = prdata_ff;
   assign pready_o          = pready_ff;
   assign pslverr_o         = pslverr_ff;
   assign link_tx_out_o     = tx_ff;
   assign rx_filtered_o     = rxf_ff;
   assign wake_irq_o        = irq_ff;
   assign wake_nmi_o        = wake_flag_ff;
   assign link_clk_halted_o = halted_ff;

endmodule

// ### testbench/vlpl_link_sva.sv
// checker for the link low-power, loopback and receive-filter block
`timescale 1ns/100ps
module vlpl_link_chk
   import vlpl_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic [11:0] paddr_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        cpu_wait_i,
   input wire logic        cpu_stop_i,
   input wire logic        tx_bit_i,
   input wire logic        link_rx_in_i,
   input wire logic        link_tx_out_o,
   input wire logic        rx_filtered_o,
   input wire logic        wake_irq_o,
   input wire logic        wake_nmi_o,
   input wire logic        link_clk_halted_o
);
   logic [4:0] hi_ff;
   logic [4:0] lo_ff;
   wire        sv_rd = psel_i && penable_i && pready_o && !pwrite_i && paddr_i == OFF_STATE_VEC;
   wire        sv_su = psel_i && !penable_i && !pwrite_i && paddr_i == OFF_STATE_VEC;
   // both sources agree, so either receive path must settle the same way
   wire        hi_ok = link_rx_in_i && tx_bit_i && !link_clk_halted_o;
   wire        lo_ok = !link_rx_in_i && !tx_bit_i && !link_clk_halted_o;
   wire [4:0]  nxt_hi = !hi_ok ? 5'h00 : (hi_ff == 5'h1F ? hi_ff : hi_ff + 5'h01);
   wire [4:0]  nxt_lo = !lo_ok ? 5'h00 : (lo_ff == 5'h1F ? lo_ff : lo_ff + 5'h01);

   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hi_ff <= 5'h00;
         lo_ff <= 5'h00;
      end
      else
      begin
         hi_ff <= nxt_hi;
         lo_ff <= nxt_lo;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   a_halt_cause: assert property ($rose(link_clk_halted_o) |-> $past(cpu_wait_i || cpu_stop_i))
      else $error("clocks halted without a cpu instruction");
   a_halt_hold: assert property (link_clk_halted_o && !sv_rd |=> link_clk_halted_o)
      else $error("halt left without wakeup acknowledge");
   a_halt_quiet: assert property (link_clk_halted_o && $past(link_clk_halted_o) |-> !link_tx_out_o)
      else $error("transmit driven while halted");
   a_nmi_in_stop: assert property ($rose(wake_nmi_o) |-> link_clk_halted_o)
      else $error("nmi raised outside stop");
   a_nmi_code: assert property (sv_su && wake_nmi_o |=> prdata_o == {24'h00_0000, SV_WAKEUP})
      else $error("wakeup code not on top");
   a_nmi_sticky: assert property (wake_nmi_o && !sv_rd |=> wake_nmi_o)
      else $error("nmi dropped without read");
   a_nmi_release: assert property (sv_rd && prdata_o == {24'h00_0000, SV_WAKEUP}
      |=> !wake_nmi_o && !link_clk_halted_o)
      else $error("wakeup read did not restart clocks");
   a_wait_irq: assert property ($rose(wake_irq_o) |-> !link_clk_halted_o)
      else $error("wait wake while halted");
   a_filt_high: assert property (hi_ff == 5'd21 |-> rx_filtered_o)
      else $error("filter missed steady high");
   a_filt_low: assert property (lo_ff == 5'd21 |-> !rx_filtered_o)
      else $error("filter missed steady low");

   c_nmi: cover property ($rose(wake_nmi_o));
   c_irq: cover property ($rose(wake_irq_o));
   c_filt: cover property ($rose(rx_filtered_o));
endmodule

bind vlpl_link vlpl_link_chk u_vlpl_link_chk (.clk_i, .arst_n_i, .paddr_i, .psel_i, .penable_i,
   .pwrite_i, .prdata_o, .pready_o, .cpu_wait_i, .cpu_stop_i, .tx_bit_i, .link_rx_in_i,
   .link_tx_out_o, .rx_filtered_o, .wake_irq_o, .wake_nmi_o, .link_clk_halted_o);

// ### testbench/vlpl_xcvr.sv
// behavioural analog transceiver: wired bus with optional loopback
`timescale 1ns/100ps
module vlpl_xcvr
(
   input  wire logic tx_i,
   input  wire logic bus_i,
   input  wire logic loop_i,
   output logic      rx_o
);
   // in loopback the shared wire is ignored and never driven
   assign rx_o = loop_i ? tx_i : (tx_i | bus_i);
endmodule

// ### testbench/tb_vlpl_link.sv
// self-checking bench for the link low-power, loopback and filter block
`timescale 1ns/100ps
module tb_vlpl_link;
   import vlpl_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        cpu_wait = 1'b0;
   logic        cpu_stop = 1'b0;
   logic        tx_bit = 1'b0;
   logic        bus = 1'b0;
   logic        xloop = 1'b0;
   wire  [31:0] prdata_o;
   wire         pready_o, pslverr_o, rx_in, tx_out, rx_filtered_o;
   wire         wake_irq_o, wake_nmi_o, halted;
   int          err_count = 0;
   int          total_checks = 0;

   always #10 clk = ~clk;

   vlpl_link #(.EOD_CYC(16'd40), .EOF_CYC(16'd56), .IDLE_CYC(16'd60)) u_vlpl_link (
      .clk_i(clk), .arst_n_i(arst_n), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .cpu_wait_i(cpu_wait), .cpu_stop_i(cpu_stop), .tx_bit_i(tx_bit),
      .link_rx_in_i(rx_in), .link_tx_out_o(tx_out), .rx_filtered_o(rx_filtered_o),
      .wake_irq_o(wake_irq_o), .wake_nmi_o(wake_nmi_o), .link_clk_halted_o(halted));
   vlpl_xcvr u_vlpl_xcvr (.tx_i(tx_out), .bus_i(bus), .loop_i(xloop), .rx_o(rx_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: a missing answer is left to the watchdog
      do
         @(posedge clk);
      while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk({e, q[30:0]}, exp);
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic pin(input logic lvl, input int n);
      @(posedge clk);
      bus <= lvl;
      wt(n);
   endtask

   task automatic do_reset();
      @(posedge clk);
      arst_n <= 1'b0;
      bus <= 1'b0;
      xloop <= 1'b0;
      tx_bit <= 1'b0;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
   endtask

   task automatic instr(input logic stp);
      @(posedge clk);
      cpu_stop <= stp;
      cpu_wait <= !stp;
      @(posedge clk);
      cpu_stop <= 1'b0;
      cpu_wait <= 1'b0;
      wt(1);
   endtask

   task automatic meas(input logic lvl);
      int n;
      pin(lvl, 0);
      n = 0;
      while (rx_filtered_o !== lvl && n < 40)
      begin
         @(negedge clk);
         n++;
      end
      chk(n >= 15 && n <= 21, 1);
   endtask

   task automatic t_basic();
      wt(1);
      chk({rx_filtered_o, wake_irq_o, wake_nmi_o, halted, tx_out}, 0);
      rd(OFF_STATUS, 0);
      wr(OFF_CTRL_ONE, 32'h0000_0001);
      rd(OFF_CTRL_ONE, 1);
      wr(OFF_CTRL_ONE, 32'h0000_0000);
      rd(12'h010, 32'h8000_0000);
   endtask

   task automatic t_filter();
      pin(1'b1, 10);
      pin(1'b0, 30);
      chk(rx_filtered_o, 0);
      meas(1'b1);
      pin(1'b0, 10);
      pin(1'b1, 30);
      chk(rx_filtered_o, 1);
      meas(1'b0);
      wt(80);
   endtask

   task automatic t_power();
      for (int k = 0; k < 3; k++)
      begin
         wr(OFF_CTRL_TWO, (k == 2) ? 32'h0000_0004 : 32'h0000_0000);
         wr(OFF_CTRL_ONE, (k == 0) ? 32'h0000_0000 : 32'h0000_0001);
         instr(k == 2);
         chk(halted, k != 0);
         rd(OFF_STATUS, (k == 0) ? 1 : 2);
         pin(1'b1, 0);
         for (int i = 0; i < 30 && (k == 0 ? wake_irq_o : wake_nmi_o) !== 1'b1; i++)
            @(negedge clk);
         chk({wake_irq_o, wake_nmi_o}, (k == 0) ? 2 : 1);
         wt(25);
         chk(halted, k != 0);
         if (k == 0)
            chk(rx_filtered_o, 1);
         else
            rd(OFF_STATE_VEC, {24'h00_0000, SV_WAKEUP});
         wt(1);
         chk({halted, wake_nmi_o}, 0);
         rd(OFF_CTRL_ONE, (k == 0) ? 0 : 1);
         rd(OFF_CTRL_TWO, (k == 2) ? 4 : 0);
         pin(1'b0, 100);
         // first pass leaves a short in-frame symbol and a frame end pending
         rd(OFF_STATE_VEC, {24'h00_0000, (k == 0) ? SV_INVALID : SV_NONE});
         rd(OFF_STATE_VEC, {24'h00_0000, (k == 0) ? SV_EOF : SV_NONE});
         rd(OFF_STATE_VEC, 32'h0000_0000);
         chk(wake_irq_o, 0);
      end
   endtask

   task automatic t_loop();
      wr(OFF_CTRL_TWO, 32'h0000_0001);
      @(posedge clk);
      tx_bit <= 1'b1;
      wt(25);
      chk({tx_out, rx_filtered_o}, 1);
      @(posedge clk);
      tx_bit <= 1'b0;
      wt(25);
      wr(OFF_CTRL_ONE, 32'h0000_0001);
      instr(1'b0);
      pin(1'b1, 30);
      chk({wake_nmi_o, halted}, 1);
      do_reset();
      @(posedge clk);
      xloop <= 1'b1;
      wr(OFF_CTRL_TWO, 32'h0000_0002);
      @(posedge clk);
      tx_bit <= 1'b1;
      wt(25);
      chk({tx_out, rx_filtered_o}, 3);
      @(posedge clk);
      tx_bit <= 1'b0;
      wt(25);
      @(posedge clk);
      xloop <= 1'b0;
      wr(OFF_CTRL_TWO, 32'h0000_0000);
      @(posedge clk);
      tx_bit <= 1'b1;
      wt(3);
      chk(tx_out, 0);
      wt(70);
      chk(tx_out, 1);
   endtask

   // 100 filtered edges in one frame, runs kept below end of data
   task automatic t_long();
      for (int i = 0; i < 50; i++)
      begin
         pin(1'b1, 22);
         pin(1'b0, 22);
      end
      wt(80);
      rd(OFF_STATE_VEC, {24'h00_0000, SV_TOO_LONG});
      rd(OFF_STATE_VEC, {24'h00_0000, SV_INVALID});
      rd(OFF_STATE_VEC, {24'h00_0000, SV_EOF});
      rd(OFF_STATE_VEC, {24'h00_0000, SV_NONE});
   endtask

   initial
   begin
      repeat (30000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial
   begin
      do_reset();
      t_basic();
      t_filter();
      t_power();
      t_long();
      t_loop();
      finish_test();
   end
endmodule
